/* design/rf_transmit_control.sv */
/*
  RF transmit control: APB register file, transmission state machine,
  payload fetch from data RAM, line encoder, synthesizer word steering,
  amplifier keying and lock-loss interrupt.
  Assumes a data RAM that returns read data one cycle after ram_rd_o
  rises, and a synthesizer that reports lock on pll_lock_i.
*/
// Operation
// - Amplitude keying carrier from tone-zero word only
// - Frequency keying: zero bits tone0, ones tone1
// - Output is ref times N plus word/8192
// - Band bit picks divider 26 or 36
// - Modulator follows serial data low or high
// - Amplitude keying toggles amplifier with data
// - FSK amplifier after settle, on throughout
// - Lock loss mutes amplifier, raises alarm
// - Crystal selectable among 26, 16, 24 MHz
// - Baud ratio from config bits 7:6
// - Processor idles during whole transfer
// - Machine reads RAM bytes, feeds encoder
// - Machine powers crystal, synthesizer, encoder
// - Config bits 2:0 select line code
`timescale 1ns/10ps
`default_nettype none
module rf_transmit_control
  import rf_tx_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pll_lock_i,
  input wire logic [7:0] ram_rdata_i,
  output logic ram_rd_o,
  output logic [7:0] ram_addr_o,
  output rf_ctl_t rf_o,
  output logic irq_o
);
  // ==========================================================
  // Decoding helpers
  // Map config bits 2:0 to a line code
  function automatic line_code_t dec_code(input logic [2:0] c);
    line_code_t m;
    m = LC_MANCH;
    if (c[0] && !c[1]) begin
      m = LC_MARK;
    end else begin
      case (c)
        3'b000: m = LC_MANCH;
        3'b100: m = LC_PWM;
        3'b010: m = LC_BP0;
        3'b110: m = LC_BP1;
        3'b011: m = LC_DBP0;
        3'b111: m = LC_DBP1;
        default: m = LC_MANCH;
      endcase
    end
    return m;
  endfunction
  // Level of one chip of a bit, cur is the present line level
  function automatic logic chip_lvl(input line_code_t m, input logic b,
                                    input logic [1:0] ch, input logic cur);
    logic v;
    v = cur;
    case (m)
      LC_MANCH: v = (ch == 2'd0) ? b : !b;
      LC_PWM: v = (ch == 2'd0) ? 1'b1 : ((ch == 2'd1) ? b : 1'b0);
      LC_MARK: v = b;
      LC_BP0: v = (ch == 2'd0) ? !cur : (b ? cur : !cur);
      LC_BP1: v = (ch == 2'd0) ? !cur : (b ? !cur : cur);
      LC_DBP0: v = (ch == 2'd0) ? (b ? cur : !cur) : !cur;
      LC_DBP1: v = (ch == 2'd0) ? (b ? !cur : cur) : !cur;
      default: v = cur;
    endcase
    return v;
  endfunction
  // ==========================================================
  // Register file state
  logic [13:0] tone0_q, tone0_d;     // Tone-zero word
  logic [13:0] tone1_q, tone1_d;     // Tone-one word
  logic [7:0] rfctl_q, rfctl_d;      // RF control second high
  logic [7:0] cfg3_q, cfg3_d;        // System config third
  logic [3:0] txctl_q, txctl_d;      // Keying and crystal select
  logic [7:0] len_q, len_d;          // Payload length in bytes
  logic [1:0] sts_q, sts_d;          // Sticky events
  logic [1:0] msk_q, msk_d;          // Event mask
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic irq_q, irq_d;
  logic wr_en, start_pulse;
  logic [1:0] ev;                    // Event pulses from the machine
  // Machine state
  tx_state_t st_q, st_d;
  logic [11:0] cnt_q, cnt_d;         // Startup and fetch counter
  logic [7:0] addr_q, addr_d;        // RAM read address
  logic [7:0] nleft_q, nleft_d;      // Bytes still to send
  logic [7:0] shr_q, shr_d;          // Byte being sent, MSB first
  logic [2:0] bit_q, bit_d;
  logic [1:0] chip_q, chip_d;
  logic [3:0] tick_q, tick_d;
  logic tx_q, tx_d;                  // Encoded serial line
  logic mute_q, mute_d;
  logic rd_q, rd_d;
  rf_ctl_t out_q, out_d;
  logic [3:0] chip_len;
  logic [1:0] last_chip;
  line_code_t code;
  logic run, fsk;
  // ==========================================================
  // APB slave: no wait cycle, pready with data in the first access cycle
  always_comb begin
    wr_en = psel_i && penable_i && rdy_q && pwrite_i;
    rdy_d = psel_i && !penable_i;
    err_d = 1'b0;
    rdata_d = rdata_q;
    start_pulse = 1'b0;
    tone0_d = tone0_q;
    tone1_d = tone1_q;
    rfctl_d = rfctl_q;
    cfg3_d = cfg3_q;
    txctl_d = txctl_q;
    len_d = len_q;
    msk_d = msk_q;
    sts_d = sts_q;
    if (psel_i && !penable_i) begin
      // Read mux, unmapped reads return zero with error
      case (paddr_i)
        OFS_TONE0_LO: rdata_d = {24'h000000, tone0_q[7:0]};
        OFS_TONE0_HI: rdata_d = {26'h0, tone0_q[13:8]};
        OFS_TONE1_LO: rdata_d = {24'h000000, tone1_q[7:0]};
        OFS_TONE1_HI: rdata_d = {26'h0, tone1_q[13:8]};
        OFS_RFCTL2H: rdata_d = {24'h000000, rfctl_q};
        OFS_SYSCFG3: rdata_d = {24'h000000, cfg3_q};
        OFS_TXCTL: rdata_d = {28'h0000000, txctl_q[3:1], 1'b0};
        OFS_TXLEN: rdata_d = {24'h000000, len_q};
        OFS_INT_STS: rdata_d = {30'h0, sts_q};
        OFS_INT_MSK: rdata_d = {30'h0, msk_q};
        OFS_STATE: rdata_d = {24'h000000, pll_lock_i, mute_q, 3'h0, st_q};
        default: begin
          rdata_d = 32'h00000000;
          err_d = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (paddr_i)
        OFS_TONE0_LO: tone0_d[7:0] = pwdata_i[7:0];
        OFS_TONE0_HI: tone0_d[13:8] = pwdata_i[5:0];
        OFS_TONE1_LO: tone1_d[7:0] = pwdata_i[7:0];
        OFS_TONE1_HI: tone1_d[13:8] = pwdata_i[5:0];
        OFS_RFCTL2H: rfctl_d = pwdata_i[7:0];
        OFS_SYSCFG3: cfg3_d = pwdata_i[7:0];
        OFS_TXCTL: begin
          txctl_d = pwdata_i[3:0];
          start_pulse = pwdata_i[START_BIT];
        end
        OFS_TXLEN: len_d = pwdata_i[7:0];
        OFS_INT_STS: sts_d = sts_q & ~pwdata_i[1:0];
        OFS_INT_MSK: msk_d = pwdata_i[1:0];
        default: sts_d = sts_q;
      endcase
    end
    // Hardware set wins over a clearing write
    sts_d = sts_d | ev;
    irq_d = |(sts_d & msk_q);
  end
  // Register stage of the slave
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tone0_q <= TONE_RST;
      tone1_q <= TONE_RST;
      rfctl_q <= CFG_RST;
      cfg3_q <= CFG_RST;
      txctl_q <= 4'h0;
      len_q <= LEN_RST;
      sts_q <= 2'b00;
      msk_q <= 2'b00;
      rdata_q <= 32'h00000000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tone0_q <= tone0_d;
      tone1_q <= tone1_d;
      rfctl_q <= rfctl_d;
      cfg3_q <= cfg3_d;
      txctl_q <= txctl_d;
      len_q <= len_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end
  // ==========================================================
  // Transmission state machine and encoder
  always_comb begin
    code = dec_code(cfg3_q[2:0]);
    fsk = txctl_q[FSK_BIT];
    case (cfg3_q[BAUD_LSB +: 2])
      2'b00: chip_len = CHIP_B00;
      2'b01: chip_len = CHIP_B01;
      2'b10: chip_len = CHIP_B10;
      default: chip_len = CHIP_B11;
    endcase
    last_chip = (code == LC_PWM) ? 2'd2 : 2'd1;
    run = (st_q == ST_FETCH) || (st_q == ST_SEND);
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    nleft_d = nleft_q;
    shr_d = shr_q;
    bit_d = bit_q;
    chip_d = chip_q;
    tick_d = tick_q;
    tx_d = tx_q;
    mute_d = mute_q;
    rd_d = 1'b0;
    ev = 2'b00;
    // Lock loss during fetch or send mutes until the next start
    if (run && !pll_lock_i && !mute_q) begin
      mute_d = 1'b1;
      ev[EV_LOCK] = 1'b1;
    end
    case (st_q)
      ST_IDLE: begin
        if (start_pulse) begin
          st_d = ST_XTAL;
          cnt_d = 12'h000;
          addr_d = RAM_BASE;
          nleft_d = len_q;
          mute_d = 1'b0;
          tx_d = 1'b0;
        end
      end
      ST_XTAL: begin
        // Crystal start-up time
        cnt_d = cnt_q + 12'h001;
        if (cnt_q == XTAL_CYC - 12'h001) begin
          st_d = ST_PLL;
          cnt_d = 12'h000;
        end
      end
      ST_PLL: begin
        // Settle counts only while lock is held
        cnt_d = pll_lock_i ? cnt_q + 12'h001 : 12'h000;
        if (pll_lock_i && cnt_q == SETTLE_CYC - 12'h001) begin
          st_d = ST_FETCH;
          cnt_d = 12'h000;
        end
      end
      ST_FETCH: begin
        // Read request, wait, capture byte
        cnt_d = cnt_q + 12'h001;
        rd_d = (cnt_q == 12'h000);
        if (cnt_q == 12'h002) begin
          shr_d = ram_rdata_i;
          addr_d = addr_q + 8'h01;
          nleft_d = nleft_q - 8'h01;
          bit_d = 3'd0;
          chip_d = 2'd0;
          tick_d = 4'h0;
          tx_d = chip_lvl(code, ram_rdata_i[7], 2'd0, tx_q);
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        tick_d = tick_q + 4'h1;
        if (tick_q == chip_len - 4'h1) begin
          tick_d = 4'h0;
          if (chip_q != last_chip) begin
            chip_d = chip_q + 2'd1;
            tx_d = chip_lvl(code, shr_q[7], chip_q + 2'd1, tx_q);
          end else if (bit_q != 3'd7) begin
            chip_d = 2'd0;
            bit_d = bit_q + 3'd1;
            shr_d = {shr_q[6:0], 1'b0};
            tx_d = chip_lvl(code, shr_q[6], 2'd0, tx_q);
          end else begin
            cnt_d = 12'h000;
            st_d = (nleft_q == 8'h00) ? ST_DONE : ST_FETCH;
          end
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
        tx_d = 1'b0;
        ev[EV_DONE] = 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase
  end
  // Front-end controls, all registered onto the outputs
  always_comb begin
    out_d.xtal_en = (st_q != ST_IDLE) && (st_q != ST_DONE);
    out_d.synth_en = (st_q == ST_PLL) || run;
    out_d.enc_en = run;
    out_d.cpu_idle = st_q != ST_IDLE && st_q != ST_DONE;
    out_d.tx_data = tx_q;
    out_d.xtal_sel = txctl_q[XSEL_LSB +: 2];
    out_d.int_div = rfctl_q[BAND_BIT] ? NDIV_HIGH : NDIV_LOW;
    // Synthesizer: ref * (int_div + fraction_word / 2^13)
    out_d.fraction_word = (fsk && tx_q) ? tone1_q : tone0_q;
    if (fsk) begin
      out_d.pa_en = run && !mute_d;
    end else begin
      out_d.pa_en = (st_q == ST_SEND) && tx_q && !mute_d;
    end
  end
  // Machine and output registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 12'h000;
      addr_q <= RAM_BASE;
      nleft_q <= 8'h00;
      shr_q <= 8'h00;
      bit_q <= 3'd0;
      chip_q <= 2'd0;
      tick_q <= 4'h0;
      tx_q <= 1'b0;
      mute_q <= 1'b0;
      rd_q <= 1'b0;
      // Divider already shows the low band while reset is held
      out_q <= '{int_div: NDIV_LOW, default: '0};
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      nleft_q <= nleft_d;
      shr_q <= shr_d;
      bit_q <= bit_d;
      chip_q <= chip_d;
      tick_q <= tick_d;
      tx_q <= tx_d;
      mute_q <= mute_d;
      rd_q <= rd_d;
      out_q <= out_d;
    end
  end
  assign prdata_o = rdata_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
  assign irq_o = irq_q;
  assign ram_rd_o = rd_q;
  assign ram_addr_o = addr_q;
  assign rf_o = out_q;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ask_carrier: assert property (
    (out_q.synth_en && !$past(fsk)) |-> out_q.fraction_word == $past(tone0_q))
    else $error("carrier word is not tone zero");
  chk_fsk_tone: assert property (
    (out_q.synth_en && $past(fsk)) |->
      out_q.fraction_word == ($past(tx_q) ? $past(tone1_q) : $past(tone0_q)))
    else $error("tone word does not follow data");
  chk_band_div: assert property (
    out_q.int_div == ($past(rfctl_q[BAND_BIT]) ? NDIV_HIGH : NDIV_LOW))
    else $error("integer divider wrong for band");
  chk_ask_keying: assert property (
    (out_q.pa_en && !$past(fsk)) |-> $past(tx_q) && $past(st_q) == ST_SEND)
    else $error("amplifier on while data low");
  chk_fsk_pa_settled: assert property (
    out_q.pa_en |-> out_q.synth_en && $past(pll_lock_i))
    else $error("amplifier before synth settled");
  chk_lock_mute: assert property (
    (run && !pll_lock_i) |=> !out_q.pa_en && sts_q[EV_LOCK])
    else $error("lock loss not muted or flagged");
  chk_idle_hold: assert property (
    (st_q == ST_IDLE && start_pulse) |=> ##1 out_q.cpu_idle [*8])
    else $error("processor not held idle");
  chk_ram_window: assert property (
    ram_rd_o |-> ram_addr_o[7] ##2 st_q == ST_SEND)
    else $error("fetch outside payload bank");
  chk_done_release: assert property (
    st_q == ST_DONE |=> ##1 !out_q.cpu_idle && !out_q.synth_en && sts_q[EV_DONE])
    else $error("not released after last byte");
  cov_frame_done: cover property (st_q == ST_DONE);
  cov_lock_loss: cover property (run && !pll_lock_i);
  cov_fsk_send: cover property (st_q == ST_SEND && fsk && out_q.pa_en);
endmodule
`default_nettype wire

/* design/rf_tx_pkg.sv */
/*
  Package for the RF transmit control block: register offsets, field
  positions, reset values, timing counts, state and line-code types and
  the packed carrier of the RF front-end controls.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package rf_tx_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_TONE0_LO = 8'h00;
  localparam logic [7:0] OFS_TONE0_HI = 8'h04;
  localparam logic [7:0] OFS_TONE1_LO = 8'h08;
  localparam logic [7:0] OFS_TONE1_HI = 8'h0C;
  localparam logic [7:0] OFS_RFCTL2H = 8'h10;
  localparam logic [7:0] OFS_SYSCFG3 = 8'h14;
  localparam logic [7:0] OFS_TXCTL = 8'h18;
  localparam logic [7:0] OFS_TXLEN = 8'h1C;
  localparam logic [7:0] OFS_INT_STS = 8'h20;
  localparam logic [7:0] OFS_INT_MSK = 8'h24;
  localparam logic [7:0] OFS_STATE = 8'h28;
  // ==========================================================
  // Field positions
  localparam int BAND_BIT = 7;      // High band select in rf control
  localparam int BAUD_LSB = 6;      // Baud ratio field, bits 7:6
  localparam int START_BIT = 0;     // Transmit control: start
  localparam int FSK_BIT = 1;       // Transmit control: frequency keying
  localparam int XSEL_LSB = 2;      // Transmit control: crystal select
  localparam int EV_DONE = 0;       // Status: transmission finished
  localparam int EV_LOCK = 1;       // Status: lock-loss alarm
  // ==========================================================
  // Reset values and fixed numbers
  localparam logic [13:0] TONE_RST = 14'h0000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [7:0] RAM_BASE = 8'h80;
  localparam logic [5:0] NDIV_LOW = 6'h1A;  // 26
  localparam logic [5:0] NDIV_HIGH = 6'h24; // 36
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int XTAL_START_US = 100;
  localparam int PLL_SETTLE_US = 50;
  localparam logic [11:0] XTAL_CYC = 12'(XTAL_START_US * CLK_MHZ);
  localparam logic [11:0] SETTLE_CYC = 12'(PLL_SETTLE_US * CLK_MHZ);
  // Chip length in clocks per baud selection 00, 01, 10, 11
  localparam logic [3:0] CHIP_B00 = 4'h2;
  localparam logic [3:0] CHIP_B01 = 4'h8;
  localparam logic [3:0] CHIP_B10 = 4'h4;
  localparam logic [3:0] CHIP_B11 = 4'h1;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_XTAL = 3'b001, ST_PLL = 3'b010,
    ST_FETCH = 3'b011, ST_SEND = 3'b100, ST_DONE = 3'b101
  } tx_state_t;
  typedef enum logic [2:0] {
    LC_MANCH = 3'b000, LC_PWM = 3'b001, LC_MARK = 3'b010,
    LC_BP0 = 3'b011, LC_BP1 = 3'b100, LC_DBP0 = 3'b101, LC_DBP1 = 3'b110
  } line_code_t;
  typedef struct packed {
    logic xtal_en;
    logic synth_en;
    logic enc_en;
    logic pa_en;
    logic cpu_idle;
    logic tx_data;
    logic [1:0] xtal_sel;
    logic [5:0] int_div;
    logic [13:0] fraction_word;
  } rf_ctl_t;
endpackage

/* sim/rf_far_side.sv */
/*
  Far-side model of the RF transmit control block: data RAM holding the
  payload and a synthesizer whose lock follows its power enable.
  Assumes one clock shared with the block and a bench that can cut lock.
*/
`timescale 1ns/10ps
`default_nettype none
module rf_far_side
  import rf_tx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ram_rd_i,
  input wire logic [7:0] ram_addr_i,
  input wire rf_ctl_t rf_i,
  input wire logic lock_drop_i,
  output logic [7:0] ram_rdata_o,
  output logic pll_lock_o
);
  // ==========================================================
  // Data RAM
  logic [7:0] mem_q [256]; // Payload image, upper bank from RAM_BASE
  logic [1:0] rd_q;        // Read pulse delay line
  logic [4:0] lock_cnt_q;  // Cycles since synthesizer power-up
  // Payload placed before any start
  initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i * 37 + 5);
  // Word launched on the edge that sees the read pulse, held one more
  // cycle, toggling garbage otherwise so a late capture shows up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_q <= 2'b00;
      ram_rdata_o <= 8'h5A;
    end else begin
      rd_q <= {rd_q[0], ram_rd_i};
      if (ram_rd_i) ram_rdata_o <= mem_q[ram_addr_i];
      else if (rd_q[0]) ram_rdata_o <= ram_rdata_o;
      else ram_rdata_o <= ~ram_rdata_o;
    end
  end
  // ==========================================================
  // Synthesizer lock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !rf_i.synth_en) lock_cnt_q <= 5'h00;
    else if (lock_cnt_q != 5'h1F) lock_cnt_q <= lock_cnt_q + 5'h01;
  end
  // Lock only after a settling delay; the bench may break it
  assign pll_lock_o = (lock_cnt_q == 5'h1F) && !lock_drop_i;
endmodule
`default_nettype wire

/* sim/tb.sv */
/*
  Self-checking bench of the RF transmit control block: APB register
  checks, ASK and FSK frames, lock loss and interrupt handling.
  Assumes the far-side model in rf_far_side and a 20 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rf_tx_pkg::*;
  // ==========================================================
  // Signals
  logic core_clk_i, rst_n_i, psel, pen, pwr, pready, pslverr, irq;
  logic ram_rd, pll_lock, lock_drop, fsk_mode, muted, tx_p1, tx_p2;
  logic drop_p1;                      // Lock cut seen one edge ago
  logic [7:0] paddr, ram_rdata, ram_addr;
  logic [31:0] pwdata, prdata;
  logic [31:0] lfsr_q = 32'h23CFFA72; // Random source
  logic [32:0] exp_q [$];             // Notes of read results
  logic [13:0] t0, t1;                // Tone words of the frame
  rf_ctl_t rf;
  int err_total, check_count, run_len, min_run, rd_count;
  rf_transmit_control i_rf_transmit_control (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pll_lock_i(pll_lock),
    .ram_rdata_i(ram_rdata), .ram_rd_o(ram_rd), .ram_addr_o(ram_addr), .rf_o(rf), .irq_o(irq));
  rf_far_side i_rf_far_side (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .ram_rd_i(ram_rd),
    .ram_addr_i(ram_addr), .rf_i(rf), .lock_drop_i(lock_drop), .ram_rdata_o(ram_rdata),
    .pll_lock_o(pll_lock));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Next state of the random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    $display("mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      close_out();
    end
  endtask
  // One frame: tone words, config, start, optional lock loss, completion
  task automatic frame(input logic f, input logic [1:0] baud, input logic [7:0] len,
                       input logic [1:0] xs, input logic drop, input logic [2:0] lc);
    lfsr_q = lfsr_next(lfsr_q);
    t0 = 14'(lfsr_q[12:0]);
    t1 = 14'(lfsr_q[28:16]);
    apb(1'b1, OFS_TONE0_LO, 32'(t0[7:0]), '0);
    apb(1'b1, OFS_TONE0_HI, 32'(t0[13:8]), '0);
    apb(1'b1, OFS_TONE1_LO, 32'(t1[7:0]), '0);
    apb(1'b1, OFS_TONE1_HI, 32'(t1[13:8]), '0);
    apb(1'b1, OFS_SYSCFG3, 32'({baud, 3'h0, lc}), '0);
    apb(1'b1, OFS_TXLEN, 32'(len), '0);
    apb(1'b1, OFS_INT_MSK, drop ? 32'h2 : 32'h3, '0);
    fsk_mode = f;
    muted = 1'b0;
    min_run = 1000;
    rd_count = 0;
    apb(1'b1, OFS_TXCTL, 32'({xs, f, 1'b1}), '0);
    @(posedge core_clk_i);
    #1 chk(33'({rf.xtal_en, rf.cpu_idle, rf.synth_en}), 33'h6, "power up order");
    chk(33'(rf.xtal_sel), 33'(xs), "crystal select");
    @(posedge core_clk_i);
    // Start while busy must be ignored; keying and crystal fields kept
    apb(1'b1, OFS_TXCTL, 32'({xs, f, 1'b1}), '0);
    if (drop) begin
      for (int k = 0; k < 5000 && rf.pa_en !== 1'b1; k++) @(posedge core_clk_i);
      if (rf.pa_en !== 1'b1) begin
        err_total++;
        close_out();
      end
      repeat (30) @(posedge core_clk_i);
      lock_drop <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      #1 chk(33'(rf.pa_en), 33'h0, "amplifier not muted");
      muted = 1'b1;
      wait_irq();
      lock_drop <= 1'b0;
      apb(1'b0, OFS_INT_STS, '0, 33'h2);
      apb(1'b1, OFS_INT_STS, 32'h2, '0);
      #1 chk(33'(irq), 33'h0, "irq after clear");
      apb(1'b1, OFS_INT_MSK, 32'h3, '0);
    end
    wait_irq();
    apb(1'b0, OFS_INT_STS, '0, 33'h1);
    apb(1'b1, OFS_INT_STS, 32'h1, '0);
    apb(1'b0, OFS_INT_STS, '0, 33'h0);
    #1 chk(33'(irq), 33'h0, "irq after clear");
    chk(33'({rf.xtal_en, rf.synth_en, rf.enc_en, rf.pa_en, rf.cpu_idle}), 33'h0,
        "power down");
    chk(33'(rd_count), 33'(len), "byte count");
    if (!drop) chk(33'(min_run), baud == 2'b00 ? 33'd2 : baud == 2'b01 ? 33'd8 :
                   baud == 2'b10 ? 33'd4 : 33'd1, "chip length");
  endtask
  // ==========================================================
  // Read result compare, oldest note first
  always @(posedge core_clk_i) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1, "read without note");
      else chk({pslverr, prdata}, exp_q.pop_front(), "read data");
    end
  end
  // ==========================================================
  // RF output watch during frames
  always @(posedge core_clk_i) begin
    if (ram_rd === 1'b1) begin
      chk(33'(ram_addr), 33'(RAM_BASE + 8'(rd_count)), "ram address");
      rd_count++;
    end
    if (rf.tx_data === 1'b1) run_len++;
    else begin
      if (run_len > 0 && run_len < min_run) min_run = run_len;
      run_len = 0;
    end
    if (rf.enc_en === 1'b1 && tx_p1 === rf.tx_data && tx_p2 === rf.tx_data) begin
      if (!fsk_mode) chk(33'(rf.fraction_word), 33'(t0), "ask word");
      if (!fsk_mode) chk(33'(rf.pa_en), 33'(rf.tx_data), "ask keying");
      if (fsk_mode) chk(33'(rf.fraction_word), 33'(rf.tx_data ? t1 : t0),
                        "fsk word");
      if (fsk_mode) chk(33'(rf.pa_en), 33'(!(muted || drop_p1)), "fsk amplifier");
    end
    if (rf.pa_en === 1'b1) chk(33'(rf.synth_en), 33'h1, "amplifier before synth");
    tx_p2 <= tx_p1;
    tx_p1 <= rf.tx_data;
    // The mute reaches the amplifier output one cycle after the cut
    drop_p1 <= lock_drop;
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n_i, psel, pen, pwr, lock_drop, fsk_mode, muted, tx_p1, tx_p2, drop_p1} = '0;
    paddr = '0;
    pwdata = '0;
    {err_total, check_count, run_len, min_run, rd_count} = '0;
    t0 = '0;
    t1 = '0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk(33'(rf.int_div), 33'(NDIV_LOW), "reset divider");
    apb(1'b0, OFS_TXLEN, '0, 33'(LEN_RST));
    apb(1'b0, OFS_TONE0_HI, '0, 33'(TONE_RST[13:8]));
    apb(1'b0, 8'h3C, '0, {1'b1, 32'h0});
    // Every line code and baud selection written and read back
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, OFS_SYSCFG3, 32'(((c % 4) << 6) | c), '0);
      apb(1'b0, OFS_SYSCFG3, '0, 33'(((c % 4) << 6) | c));
    end
    apb(1'b1, OFS_RFCTL2H, 32'h80, '0);
    #1 chk(33'(rf.int_div), 33'(NDIV_HIGH), "high band divider");
    apb(1'b1, OFS_RFCTL2H, 32'h0, '0);
    #1 chk(33'(rf.int_div), 33'(NDIV_LOW), "low band divider");
    // Manchester ASK, PWM FSK, bi-phase FSK with lock loss
    frame(1'b0, 2'b11, 8'h02, 2'd0, 1'b0, 3'b000);
    frame(1'b1, 2'b01, 8'h01, 2'd1, 1'b0, 3'b100);
    frame(1'b1, 2'b00, 8'h01, 2'd2, 1'b1, 3'b010);
    close_out();
  end
endmodule
`default_nettype wire
